// ---- hdl/calendar_clock_registers.sv ----
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none

module calendar_clock_registers
#(
  parameter int SECOND_CYCLES = clock_regs_pkg::SECOND_CYCLES
)
(
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Power mode and analog trim.
  input wire logic sleep_mode,
  output logic [6:0] crystal_trim
);

  // ***************************************************
  // Helper functions.
  // ***************************************************

  // Leap years are those whose value is a multiple of four.
  function automatic logic [4:0] days_in_month(input logic [3:0] month, input logic [7:0] year);
    logic leap;
    leap = (year[1:0] == 2'b00);
    case (month)
      4'h4, 4'h6, 4'h9, 4'hb: days_in_month = 5'd30;
      clock_regs_pkg::MONTH_FEB: days_in_month = leap ? 5'd29 : 5'd28;
      default: days_in_month = 5'd31;
    endcase
  endfunction

  // Index match for an address that lies inside the register window.
  function automatic logic hits(input logic [31:0] addr, input logic [13:0] idx);
    hits = (addr[31:16] == 16'h0) && (addr[15:2] == idx);
  endfunction

  // ***************************************************
  // Bus slave.
  // ***************************************************

  second_tick_if tick_link ();

  clock_regs_pkg::bus_state_t bus_state;
  logic wr_pend;
  logic [31:0] wr_addr;
  logic [31:0] rd_addr;
  logic addr_valid;
  logic take_read;
  logic take_write;

  // A transfer is taken when selected, active and the bus is ready.
  assign addr_valid = hsel && hready && (htrans == clock_regs_pkg::HTRANS_NONSEQ ||
                                         htrans == clock_regs_pkg::HTRANS_SEQ);
  assign take_read = addr_valid && !hwrite;
  assign take_write = addr_valid && hwrite;

  // Reads take one wait state so that a write just before them is seen.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bus_state <= clock_regs_pkg::BUS_IDLE;
      hreadyout <= 1'b1;
      wr_pend <= 1'b0;
      wr_addr <= 32'h0;
      rd_addr <= 32'h0;
    end
    else
    begin
      wr_pend <= take_write;
      if (take_write)
      begin
        wr_addr <= haddr;
      end
      case (bus_state)
        clock_regs_pkg::BUS_IDLE:
        begin
          if (take_read)
          begin
            rd_addr <= haddr;
            hreadyout <= 1'b0;
            bus_state <= clock_regs_pkg::BUS_READ_WAIT;
          end
        end
        clock_regs_pkg::BUS_READ_WAIT:
        begin
          hreadyout <= 1'b1;
          bus_state <= clock_regs_pkg::BUS_IDLE;
        end
        default:
        begin
          hreadyout <= 1'b1;
          bus_state <= clock_regs_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  // The response is always OKAY.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hresp <= 1'b0;
    end
    else
    begin
      hresp <= 1'b0;
    end
  end

  // ***************************************************
  // Write decode.
  // ***************************************************

  logic unlocked;
  logic wr_unlock;
  logic wr_restart;
  logic wr_trim;
  logic wr_coarse;
  logic wr_fine;
  logic cal_ok;
  logic wr_sec;
  logic wr_min;
  logic wr_hour;
  logic wr_wday;
  logic wr_date;
  logic wr_month;
  logic wr_year;

  assign wr_unlock = wr_pend && hits(wr_addr, clock_regs_pkg::IDX_WRITE_UNLOCK);
  assign wr_restart = wr_pend && hits(wr_addr, clock_regs_pkg::IDX_SUBSEC_RESTART);
  assign wr_trim = wr_pend && hits(wr_addr, clock_regs_pkg::IDX_CRYSTAL_TRIM);
  assign wr_coarse = wr_pend && hits(wr_addr, clock_regs_pkg::IDX_COARSE_ADJUST);
  assign wr_fine = wr_pend && hits(wr_addr, clock_regs_pkg::IDX_FINE_ADJUST);
  assign cal_ok = wr_pend && unlocked;
  assign wr_sec = cal_ok && hits(wr_addr, clock_regs_pkg::IDX_SECONDS);
  assign wr_min = cal_ok && hits(wr_addr, clock_regs_pkg::IDX_MINUTES);
  assign wr_hour = cal_ok && hits(wr_addr, clock_regs_pkg::IDX_HOURS);
  assign wr_wday = cal_ok && hits(wr_addr, clock_regs_pkg::IDX_WEEKDAY);
  assign wr_date = cal_ok && hits(wr_addr, clock_regs_pkg::IDX_DATE);
  assign wr_month = cal_ok && hits(wr_addr, clock_regs_pkg::IDX_MONTH);
  assign wr_year = cal_ok && hits(wr_addr, clock_regs_pkg::IDX_YEAR);

  // one write per unlock
  // The unlock is armed by its own write and spent by any other write.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      unlocked <= 1'b0;
    end
    else if (wr_pend)
    begin
      unlocked <= wr_unlock;
    end
  end

  // ***************************************************
  // Control and trim registers.
  // ***************************************************

  logic restart_bit;
  logic [1:0] fine_rate_adjust;
  logic [16:0] coarse_rate_adjust;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      restart_bit <= 1'b0;
      crystal_trim <= clock_regs_pkg::CRYSTAL_TRIM_RESET;
      fine_rate_adjust <= clock_regs_pkg::FINE_ADJUST_RESET;
      coarse_rate_adjust <= clock_regs_pkg::COARSE_ADJUST_RESET;
    end
    else
    begin
      if (wr_restart)
      begin
        restart_bit <= hwdata[0];
      end
      if (wr_trim)
      begin
        crystal_trim <= hwdata[6:0];
      end
      if (wr_fine)
      begin
        fine_rate_adjust <= hwdata[1:0];
      end
      if (wr_coarse)
      begin
        coarse_rate_adjust <= hwdata[16:0];
      end
    end
  end

  // ***************************************************
  // Rate correction and second divider.
  // ***************************************************

  logic sleep_meta;
  logic sleep_sync;
  logic [1:0] quarter;
  logic [31:0] coarse_offset;
  logic [31:0] fine_step;

  // The sleep pin comes from outside and is synchronised first.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sleep_meta <= 1'b0;
      sleep_sync <= 1'b0;
    end
    else
    begin
      sleep_meta <= sleep_mode;
      sleep_sync <= sleep_meta;
    end
  end

  // Quarter counter spreads the fine step over four seconds.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      quarter <= 2'h0;
    end
    else if (tick_link.tick)
    begin
      quarter <= quarter + 2'h1;
    end
  end

  // coarse and fine combine
  // Outside sleep, each coarse step above nominal shortens the second by one cycle; the
  // fine field drops one more cycle in that many seconds out of four.
  assign coarse_offset = 32'(coarse_rate_adjust) - 32'(clock_regs_pkg::COARSE_ADJUST_NOMINAL);
  assign fine_step = (quarter < fine_rate_adjust) ? 32'h1 : 32'h0;
  assign tick_link.period = sleep_sync ? 32'(SECOND_CYCLES) :
                            32'(SECOND_CYCLES) - coarse_offset - fine_step;
  assign tick_link.restart = wr_restart && hwdata[0];

  second_divider divider_inst (
    .hclk(hclk),
    .hresetn(hresetn),
    .link(tick_link)
  );

  // ***************************************************
  // Calendar counters.
  // ***************************************************

  logic [5:0] clock_seconds;
  logic [5:0] clock_minutes;
  logic [4:0] clock_hours;
  logic [2:0] clock_weekday;
  logic [4:0] clock_date;
  logic [3:0] clock_month;
  logic [7:0] clock_year;
  logic sec_wrap;
  logic min_wrap;
  logic hour_wrap;
  logic date_wrap;
  logic month_wrap;

  assign sec_wrap = tick_link.tick && (clock_seconds >= clock_regs_pkg::SECONDS_MAX);
  assign min_wrap = sec_wrap && (clock_minutes >= clock_regs_pkg::MINUTES_MAX);
  assign hour_wrap = min_wrap && (clock_hours >= clock_regs_pkg::HOURS_MAX);
  assign date_wrap = hour_wrap && (clock_date >= days_in_month(clock_month, clock_year));
  assign month_wrap = date_wrap && (clock_month >= clock_regs_pkg::MONTH_LAST);

  // write sets time
  // A written field wins over its own increment in the same cycle.
  always_ff @(posedge hclk)
  begin
    if (wr_sec)
      clock_seconds <= hwdata[5:0];
    else if (sec_wrap)
      clock_seconds <= 6'h0;
    else if (tick_link.tick)
      clock_seconds <= clock_seconds + 6'h1;
    if (wr_min)
      clock_minutes <= hwdata[5:0];
    else if (min_wrap)
      clock_minutes <= 6'h0;
    else if (sec_wrap)
      clock_minutes <= clock_minutes + 6'h1;
    if (wr_hour)
      clock_hours <= hwdata[4:0];
    else if (hour_wrap)
      clock_hours <= 5'h0;
    else if (min_wrap)
      clock_hours <= clock_hours + 5'h1;
    if (wr_wday)
      clock_weekday <= hwdata[2:0];
    else if (hour_wrap)
      clock_weekday <= (clock_weekday >= clock_regs_pkg::WEEKDAY_LAST) ?
                       clock_regs_pkg::WEEKDAY_FIRST : clock_weekday + 3'h1;
    if (wr_date)
      clock_date <= hwdata[4:0];
    else if (date_wrap)
      clock_date <= clock_regs_pkg::DATE_FIRST;
    else if (hour_wrap)
      clock_date <= clock_date + 5'h1;
    if (wr_month)
      clock_month <= hwdata[3:0];
    else if (month_wrap)
      clock_month <= clock_regs_pkg::MONTH_FIRST;
    else if (date_wrap)
      clock_month <= clock_month + 4'h1;
    if (wr_year)
      clock_year <= hwdata[7:0];
    else if (month_wrap)
      clock_year <= (clock_year >= clock_regs_pkg::YEAR_LAST) ? 8'h0 : clock_year + 8'h1;
  end

  // ***************************************************
  // Read multiplexer.
  // ***************************************************

  logic [31:0] read_value;

  // Unmapped addresses and the unlock location read as zero.
  assign read_value =
    hits(rd_addr, clock_regs_pkg::IDX_SUBSEC_RESTART) ? {31'h0, restart_bit} :
    hits(rd_addr, clock_regs_pkg::IDX_CRYSTAL_TRIM) ? {25'h0, crystal_trim} :
    hits(rd_addr, clock_regs_pkg::IDX_SECONDS) ? {26'h0, clock_seconds} :
    hits(rd_addr, clock_regs_pkg::IDX_MINUTES) ? {26'h0, clock_minutes} :
    hits(rd_addr, clock_regs_pkg::IDX_HOURS) ? {27'h0, clock_hours} :
    hits(rd_addr, clock_regs_pkg::IDX_WEEKDAY) ? {29'h0, clock_weekday} :
    hits(rd_addr, clock_regs_pkg::IDX_DATE) ? {27'h0, clock_date} :
    hits(rd_addr, clock_regs_pkg::IDX_MONTH) ? {28'h0, clock_month} :
    hits(rd_addr, clock_regs_pkg::IDX_YEAR) ? {24'h0, clock_year} :
    hits(rd_addr, clock_regs_pkg::IDX_COARSE_ADJUST) ? {15'h0, coarse_rate_adjust} :
    hits(rd_addr, clock_regs_pkg::IDX_FINE_ADJUST) ? {30'h0, fine_rate_adjust} :
    32'h0;

  // Read data is loaded in the wait state and held until the next read.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h0;
    end
    else if (bus_state == clock_regs_pkg::BUS_READ_WAIT)
    begin
      hrdata <= read_value;
    end
  end

endmodule

`default_nettype wire

// ---- hdl/clock_regs_pkg.sv ----
package clock_regs_pkg;

  // ***************************************************
  // Register indices; byte address is four times each.
  // ***************************************************
  localparam logic [13:0] IDX_SUBSEC_RESTART = 14'h2010;
  localparam logic [13:0] IDX_CRYSTAL_TRIM = 14'h2011;
  localparam logic [13:0] IDX_SECONDS = 14'h2015;
  localparam logic [13:0] IDX_MINUTES = 14'h2016;
  localparam logic [13:0] IDX_HOURS = 14'h2017;
  localparam logic [13:0] IDX_WEEKDAY = 14'h2018;
  localparam logic [13:0] IDX_DATE = 14'h2019;
  localparam logic [13:0] IDX_MONTH = 14'h201a;
  localparam logic [13:0] IDX_YEAR = 14'h201b;
  localparam logic [13:0] IDX_COARSE_ADJUST = 14'h201c;
  localparam logic [13:0] IDX_FINE_ADJUST = 14'h201e;
  localparam logic [13:0] IDX_WRITE_UNLOCK = 14'h201f;

  // ***************************************************
  // Reset and nominal values of the trim and rate fields.
  // ***************************************************
  localparam logic [6:0] CRYSTAL_TRIM_RESET = 7'h40;
  localparam logic [1:0] FINE_ADJUST_RESET = 2'h0;
  localparam logic [16:0] COARSE_ADJUST_RESET = 17'h10000;
  localparam logic [16:0] COARSE_ADJUST_NOMINAL = 17'h10000;

  // ***************************************************
  // Calendar limits.
  // ***************************************************
  localparam logic [5:0] SECONDS_MAX = 6'h3b;
  localparam logic [5:0] MINUTES_MAX = 6'h3b;
  localparam logic [4:0] HOURS_MAX = 5'h17;
  localparam logic [2:0] WEEKDAY_FIRST = 3'h1;
  localparam logic [2:0] WEEKDAY_LAST = 3'h7;
  localparam logic [4:0] DATE_FIRST = 5'h01;
  localparam logic [3:0] MONTH_FIRST = 4'h1;
  localparam logic [3:0] MONTH_LAST = 4'hc;
  localparam logic [3:0] MONTH_FEB = 4'h2;
  localparam logic [7:0] YEAR_LAST = 8'h63;

  // ***************************************************
  // Time base: clock rate and length of one second.
  // ***************************************************
  localparam longint CLOCK_HZ = 125000000;
  localparam longint SECOND_S = 1;
  localparam int SECOND_CYCLES = int'(CLOCK_HZ * SECOND_S);

  // Bus transfer types.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;

  // Bus slave states.
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_READ_WAIT = 2'b10
  } bus_state_t;

endpackage

// ---- hdl/second_tick_if.sv ----
`timescale 1ns/1ns
`default_nettype none

// Link between the register block and the second divider.
interface second_tick_if;
  logic restart;
  logic [31:0] period;
  logic tick;

  modport control (output restart, output period, input tick);
  modport divider (input restart, input period, output tick);
endinterface

`default_nettype wire

// ---- hdl/second_divider.sv ----
`timescale 1ns/1ns
`default_nettype none

// Counts clock cycles and pulses tick once per adjusted second.
module second_divider
(
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Link to the register block.
  second_tick_if.divider link
);

  logic [31:0] count;
  logic [31:0] next_count;
  logic last_cycle;

  // The last cycle of a second is one short of the period.
  assign last_cycle = (count >= link.period - 32'h1);
  assign next_count = (link.restart || last_cycle) ? 32'h0 : count + 32'h1;

  // ***************************************************
  // Sub-second counter.
  // ***************************************************

  // Restart forces the count back to its initial value.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      count <= 32'h0;
      link.tick <= 1'b0;
    end
    else
    begin
      count <= next_count;
      link.tick <= last_cycle && !link.restart;
    end
  end

endmodule

`default_nettype wire

// ---- tb/calendar_clock_registers_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// Bus timing and trim field checker.
// ****************************************
module calendar_clock_registers_monitor
(
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Bus slave side.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Power mode and trim.
  input wire logic sleep_mode,
  input wire logic [6:0] crystal_trim
);
  logic fresh;
  logic pend;
  logic [6:0] want_trim;
  wire take = hsel && hready && htrans[1];
  wire trim_hit = haddr == {16'h0, clock_regs_pkg::IDX_CRYSTAL_TRIM, 2'b00};
  wire quiet_hit = haddr == {16'h0, clock_regs_pkg::IDX_WRITE_UNLOCK, 2'b00} || haddr == 32'h8048;

  // First edge after reset, and the trim value a write will bring.
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      fresh <= 1'b1;
      pend <= 1'b0;
    end
    else
    begin
      fresh <= 1'b0;
      pend <= take && hwrite && trim_hit;
    end

  // The data phase word of a trim write.
  always_ff @(posedge hclk)
    if (pend)
      want_trim <= hwdata[6:0];

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence rd_taken; take && !hwrite; endsequence
  sequence wr_taken; take && hwrite; endsequence
  sequence one_wait; !hreadyout ##1 hreadyout; endsequence

  a_resp_always_okay: assert property (hresp == 1'b0)
    else $error("error response seen");
  a_read_one_wait: assert property (rd_taken |=> one_wait)
    else $error("read wait state wrong");
  a_write_no_wait: assert property (wr_taken |=> hreadyout)
    else $error("write stalled");
  a_trim_reset_value: assert property (fresh |-> crystal_trim == 7'h40)
    else $error("trim not at reset value");
  a_trim_write_load: assert property (wr_taken ##0 trim_hit |-> ##[2:3] crystal_trim == want_trim)
    else $error("trim write not applied");
  a_trim_held: assert property ($changed(crystal_trim) |-> $past(pend) || $past(pend, 2))
    else $error("trim changed without write");
  a_read_upper_zero: assert property ($rose(hreadyout) |-> hrdata[31:17] == 15'h0)
    else $error("upper read bits set");
  a_quiet_read_zero: assert property (rd_taken ##0 quiet_hit |-> ##2 hrdata == 32'h0)
    else $error("unlock or unmapped read not zero");
endmodule

bind calendar_clock_registers calendar_clock_registers_monitor mon (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .sleep_mode(sleep_mode), .crystal_trim(crystal_trim));

`default_nettype wire

// ---- tb/test_calendar_clock_registers.sv ----
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// Register and calendar bench.
// ****************************************
module test_calendar_clock_registers;
  localparam int SC = 100;
  logic hclk, hresetn, hsel, hwrite, sleep_mode, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd, v;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [6:0] crystal_trim;
  wire hready = hreadyout;
  int failures = 0, n_tests = 0, cyc = 0, t0;
  int exp_t[7];
  int corner[5][7] = '{'{59, 59, 23, 7, 28, 2, 4}, '{59, 59, 23, 7, 28, 2, 1},
    '{59, 59, 23, 3, 31, 12, 99}, '{59, 59, 23, 1, 30, 4, 10}, '{59, 59, 23, 6, 29, 2, 0}};

  calendar_clock_registers #(.SECOND_CYCLES(SC)) uut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .sleep_mode(sleep_mode), .crystal_trim(crystal_trim));

  // Free-running bus clock.
  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  // Cycle count and hang guard.
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      failures++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (failures == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want)
    begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, want, seen);
    end
  endtask

  task automatic wait_ready();
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  task automatic bus_write(input logic [13:0] idx, input logic [31:0] d);
    haddr <= {16'h0, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= 1'b1;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
  endtask

  task automatic bus_read(input logic [13:0] idx, output logic [31:0] d);
    haddr <= {16'h0, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= 1'b0;
    wait_ready();
    htrans <= 2'h0;
    wait_ready();
    d = hrdata;
  endtask

  task automatic restart();
    bus_write(clock_regs_pkg::IDX_SUBSEC_RESTART, 32'h1);
    t0 = cyc;
  endtask

  // Unlock, then load one calendar field; seconds is field 0.
  task automatic set_cal(input int i, input int val);
    bus_write(clock_regs_pkg::IDX_WRITE_UNLOCK, 32'h0);
    bus_write(clock_regs_pkg::IDX_SECONDS + 14'(i), 32'(val));
  endtask

  task automatic check_cal();
    for (int i = 0; i < 7; i++)
    begin
      bus_read(clock_regs_pkg::IDX_SECONDS + 14'(i), rd);
      check("calendar field", rd, 32'(exp_t[i]));
    end
  endtask

  function automatic int mdays(input int mo, input int yr);
    if (mo == 2)
      return (yr % 4 == 0) ? 29 : 28;
    if (mo == 4 || mo == 6 || mo == 9 || mo == 11)
      return 30;
    return 31;
  endfunction

  // Advances the expected calendar by one second.
  task automatic step_expect();
    int lim[3] = '{59, 59, 23};
    bit carry = 1'b1;
    for (int i = 0; i < 3; i++)
      if (carry)
      begin
        exp_t[i]++;
        carry = exp_t[i] > lim[i];
        if (carry) exp_t[i] = 0;
      end
    if (carry)
    begin
      exp_t[3] = (exp_t[3] == 7) ? 1 : exp_t[3] + 1;
      exp_t[4]++;
      if (exp_t[4] > mdays(exp_t[5], exp_t[6]))
      begin
        exp_t[4] = 1;
        exp_t[5]++;
        if (exp_t[5] > 12)
        begin
          exp_t[5] = 1;
          exp_t[6] = (exp_t[6] == 99) ? 0 : exp_t[6] + 1;
        end
      end
    end
  endtask

  // Main sequence.
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    sleep_mode = 1'b0;
    void'($urandom(69));
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    bus_read(clock_regs_pkg::IDX_CRYSTAL_TRIM, rd);
    check("trim reset", rd, 32'h40);
    bus_read(clock_regs_pkg::IDX_FINE_ADJUST, rd);
    check("fine reset", rd, 32'h0);
    bus_read(clock_regs_pkg::IDX_SUBSEC_RESTART, rd);
    check("restart reset", rd, 32'h0);
    bus_read(14'h2012, rd);
    check("unmapped read", rd, 32'h0);
    for (int k = 0; k < 4; k++)
    begin
      v = $urandom;
      bus_write(clock_regs_pkg::IDX_CRYSTAL_TRIM, v);
      bus_write(clock_regs_pkg::IDX_FINE_ADJUST, v);
      bus_read(clock_regs_pkg::IDX_CRYSTAL_TRIM, rd);
      check("trim", rd, {25'h0, v[6:0]});
      bus_read(clock_regs_pkg::IDX_FINE_ADJUST, rd);
      check("fine", rd, {30'h0, v[1:0]});
      check("trim port", {25'h0, crystal_trim}, {25'h0, v[6:0]});
    end
    bus_write(clock_regs_pkg::IDX_FINE_ADJUST, 32'h0);
    restart();
    set_cal(0, 10);
    bus_write(clock_regs_pkg::IDX_SECONDS, 32'h1e);
    bus_write(clock_regs_pkg::IDX_WRITE_UNLOCK, 32'h0);
    bus_write(14'h2012, 32'h0);
    bus_write(clock_regs_pkg::IDX_SECONDS, 32'h28);
    bus_read(clock_regs_pkg::IDX_SECONDS, rd);
    check("locked seconds", rd, 32'ha);
    bus_write(clock_regs_pkg::IDX_WRITE_UNLOCK, 32'h0);
    bus_read(clock_regs_pkg::IDX_WRITE_UNLOCK, rd);
    check("unlock read", rd, 32'h0);
    bus_write(clock_regs_pkg::IDX_SECONDS, 32'h14);
    bus_read(clock_regs_pkg::IDX_SECONDS, rd);
    check("unlocked seconds", rd, 32'h14);
    for (int c = 0; c < 9; c++)
    begin
      if (c < 5)
        exp_t = corner[c];
      else
      begin
        exp_t[0] = 59 - int'($urandom % 2);
        exp_t[1] = 59 - int'($urandom % 2);
        exp_t[2] = 23 - int'($urandom % 2);
        exp_t[3] = 1 + int'($urandom % 7);
        exp_t[5] = 1 + int'($urandom % 12);
        exp_t[6] = int'($urandom % 100);
        exp_t[4] = 1 + int'($urandom % mdays(exp_t[5], exp_t[6]));
      end
      restart();
      for (int i = 0; i < 7; i++) set_cal(i, exp_t[i]);
      check_cal();
      step_expect();
      while (cyc < t0 + SC + 10) @(posedge hclk);
      check_cal();
    end
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check("trim port after reset", {25'h0, crystal_trim}, 32'h40);
    check_cal();
    bus_write(clock_regs_pkg::IDX_COARSE_ADJUST, 32'h1003c);
    bus_read(clock_regs_pkg::IDX_COARSE_ADJUST, rd);
    check("coarse", rd, 32'h1003c);
    for (int s = 0; s < 2; s++)
    begin
      sleep_mode <= (s == 1);
      repeat (4) @(posedge hclk);
      restart();
      set_cal(0, 0);
      while (cyc < t0 + 60) @(posedge hclk);
      bus_read(clock_regs_pkg::IDX_SECONDS, rd);
      check("seconds after trimmed period", rd, (s == 1) ? 32'h0 : 32'h1);
    end
    report_and_stop();
  end
endmodule

`default_nettype wire
